// ### hcd_config_decoder.sv
// Purpose: loads option bytes and string tables from the hub configuration image and derives descriptors and pins
// Assumes: image reader answers each held read request with a one-cycle rd_valid_i pulse
// Notes: hub descriptor requests arriving before the image is loaded are stalled
`timescale 1ns/10ps
`default_nettype none

module hcd_config_decoder
    import hcd_pkg::*;
#(
    parameter int PORTS = 4,
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // configuration image reader
    output logic rd_req_o,
    output logic [ADDR_W-1:0] rd_addr_o,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    // setup requests and answers
    input wire hcd_setup_type setup_i,
    output hcd_resp_type resp_o,
    // derived descriptor fields
    output logic cfg_ready_o,
    output logic hs_enable_o,
    output logic multi_tt_o,
    output logic self_power_o,
    output logic [7:0] nbr_ports_o,
    output logic [15:0] hub_char_o,
    output logic [7:0] removable_o,
    output logic [55:0] string_idx_o,
    // port pins and hub-side controls
    input wire logic [PORTS-1:0] amber_on_i,
    input wire logic [PORTS-1:0] green_on_i,
    input wire logic [PORTS-1:0] pwr_on_i,
    input wire logic [PORTS-1:0] oc_pin_i,
    output logic [PORTS-1:0] amber_o,
    output logic [PORTS-1:0] green_o,
    output logic [PORTS-1:0] pwr_o,
    output logic [PORTS-1:0] oc_o
);

    typedef enum logic [2:0] {
        LD_HDR = 3'b001,
        LD_TAB = 3'b010,
        LD_DONE = 3'b100
    } hcd_load_type;

    // count of set bits in the usable mask
    function automatic logic [7:0] ones4(input logic [3:0] m);
        ones4 = {7'h00, m[0]} + {7'h00, m[1]} + {7'h00, m[2]} + {7'h00, m[3]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // image loader
    hcd_load_type state_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] opt_a_reg, opt_b_reg, langs_reg, strmap_reg, usable_reg, detach_reg;
    logic [7:0] tab_mem [0:TABLE_BYTES-1];
    logic langs_ok;
    logic [ADDR_W-1:0] tab_end;

    assign langs_ok = (langs_reg != 8'h00) && (langs_reg <= MAX_LANGS);
    // eight tables of 2N bytes each: language codes then seven pointer tables
    assign tab_end = ADDR_W'(IMG_TABLE_OFS) + ADDR_W'({langs_reg, 4'h0});

    // fetch sequence: header bytes first, then the tables only when strings are on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= LD_HDR;
            addr_reg <= ADDR_W'(IMG_OPT_A_OFS);
        end else begin
            case (state_reg)
                LD_HDR: begin
                    if (rd_valid_i) begin
                        if (addr_reg == ADDR_W'(IMG_DETACH_OFS)) begin
                            state_reg <= langs_ok ? LD_TAB : LD_DONE;
                            addr_reg <= ADDR_W'(IMG_TABLE_OFS);
                        end else begin
                            addr_reg <= addr_reg + 1'b1;
                        end
                    end
                end
                LD_TAB: begin
                    if (rd_valid_i) begin
                        if (addr_reg == tab_end - 1'b1) begin
                            state_reg <= LD_DONE;
                        end
                        addr_reg <= addr_reg + 1'b1;
                    end
                end
                LD_DONE: begin
                    state_reg <= LD_DONE; // held until the next reset
                end
                default: begin
                    state_reg <= LD_HDR;
                end
            endcase
        end
    end

    assign rd_req_o = (state_reg != LD_DONE);
    assign rd_addr_o = addr_reg;
    assign cfg_ready_o = (state_reg == LD_DONE);

    // latch header bytes; nothing changes them once loading is over
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_a_reg <= OPT_A_RST;
            opt_b_reg <= OPT_B_RST;
            langs_reg <= 8'h00;
            strmap_reg <= 8'h00;
            usable_reg <= 8'h00;
            detach_reg <= DETACH_RST;
        end else if (state_reg == LD_HDR && rd_valid_i) begin
            case (addr_reg)
                ADDR_W'(IMG_OPT_A_OFS): opt_a_reg <= rd_data_i;
                ADDR_W'(IMG_OPT_B_OFS): opt_b_reg <= rd_data_i;
                ADDR_W'(IMG_LANGS_OFS): langs_reg <= rd_data_i;
                ADDR_W'(IMG_STRMAP_OFS): strmap_reg <= rd_data_i;
                ADDR_W'(IMG_USABLE_OFS): usable_reg <= rd_data_i;
                ADDR_W'(IMG_DETACH_OFS): detach_reg <= rd_data_i;
                default: opt_a_reg <= opt_a_reg;
            endcase
        end
    end

    // table bytes are kept raw, low byte first; string bodies stay in the image
    // and are expected to start with their length then type 03h
    always_ff @(posedge clk_i) begin
        if (state_reg == LD_TAB && rd_valid_i) begin
            tab_mem[9'(addr_reg - ADDR_W'(IMG_TABLE_OFS))] <= rd_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // descriptor fields
    logic accept_zero_desc_type, compound_flag, fs_only_flag, indicators_off;
    logic ganged_power_switch, one_translator_only;
    logic amber_led_pol, green_led_pol, self_power_capable, led_square_wave_gate;
    logic pwr_switch_pol, oc_input_pol, oc_detect_disable, oc_per_port_report;

    assign accept_zero_desc_type = opt_a_reg[OPT_ACCEPT_ZERO_BIT];
    assign compound_flag = opt_a_reg[OPT_COMPOUND_BIT];
    assign fs_only_flag = opt_a_reg[OPT_FS_ONLY_BIT];
    assign indicators_off = opt_a_reg[OPT_IND_OFF_BIT];
    assign ganged_power_switch = opt_a_reg[OPT_GANGED_BIT];
    assign one_translator_only = opt_a_reg[OPT_ONE_TT_BIT];
    assign amber_led_pol = opt_b_reg[OPT_AMBER_POL_BIT];
    assign green_led_pol = opt_b_reg[OPT_GREEN_POL_BIT];
    assign self_power_capable = opt_b_reg[OPT_SELF_PWR_BIT];
    assign led_square_wave_gate = opt_b_reg[OPT_SQ_GATE_BIT];
    assign pwr_switch_pol = opt_b_reg[OPT_PWR_POL_BIT];
    assign oc_input_pol = opt_b_reg[OPT_OC_POL_BIT];
    assign oc_detect_disable = opt_b_reg[OPT_OC_OFF_BIT];
    assign oc_per_port_report = opt_b_reg[OPT_OC_PER_PORT_BIT];

    assign hs_enable_o = ~fs_only_flag;
    assign multi_tt_o = ~one_translator_only;
    assign self_power_o = self_power_capable;
    assign nbr_ports_o = ones4(usable_reg[3:0]);
    assign removable_o = {3'b000, detach_reg[3:0], 1'b0};

    // ganged switching forces global protection unless detection is off
    always_comb begin
        hub_char_o = 16'h0000;
        hub_char_o[1:0] = ganged_power_switch ? 2'b00 : 2'b01;
        hub_char_o[HC_COMPOUND_BIT] = compound_flag;
        hub_char_o[HC_OC_PER_PORT_BIT] = oc_per_port_report & ~ganged_power_switch;
        hub_char_o[HC_OC_NONE_BIT] = oc_detect_disable;
        hub_char_o[HC_IND_BIT] = ~indicators_off;
    end

    // seven string indices, one byte each, manufacturer in the low byte
    always_comb begin
        string_idx_o = 56'h0;
        for (int i = 0; i < 7; i++) begin
            string_idx_o[i*8 +: 8] = (langs_ok && strmap_reg[i]) ? 8'(i + 1) : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // indicator square wave
    logic [15:0] led_div_reg;
    logic [15:0] sq_cnt_reg;
    logic sq_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sq_cnt_reg <= 16'h0000;
            sq_reg <= 1'b0;
        end else if (sq_cnt_reg >= led_div_reg) begin
            sq_cnt_reg <= 16'h0000;
            sq_reg <= ~sq_reg;
        end else begin
            sq_cnt_reg <= sq_cnt_reg + 1'b1;
        end
    end

    // leds and power switches are registered so pins never glitch
    logic [PORTS-1:0] ind_gate;
    assign ind_gate = (led_square_wave_gate ? {PORTS{sq_reg}} : {PORTS{1'b1}}) & {PORTS{~indicators_off}};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amber_o <= {PORTS{1'b1}};
            green_o <= {PORTS{1'b1}};
            pwr_o <= {PORTS{1'b1}};
        end else begin
            amber_o <= (amber_on_i & ind_gate) ^ {PORTS{~amber_led_pol}};
            green_o <= (green_on_i & ind_gate) ^ {PORTS{~green_led_pol}};
            pwr_o <= (pwr_on_i & {PORTS{cfg_ready_o}}) ^ {PORTS{~pwr_switch_pol}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // over-current sense: pins pass two flops before any logic
    logic [PORTS-1:0] oc_s1_reg, oc_s2_reg;
    logic [PORTS-1:0] oc_act;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc_s1_reg <= '0;
            oc_s2_reg <= '0;
        end else begin
            oc_s1_reg <= oc_pin_i;
            oc_s2_reg <= oc_s1_reg;
        end
    end

    assign oc_act = (oc_s2_reg ^ {PORTS{~oc_input_pol}}) & usable_reg[PORTS-1:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc_o <= '0;
        end else if (oc_detect_disable || !cfg_ready_o) begin
            oc_o <= '0;
        end else if (oc_per_port_report && !ganged_power_switch) begin
            oc_o <= oc_act;
        end else begin
            oc_o <= {PORTS{|oc_act}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // setup request decode; answered one cycle after the request
    logic is_hub_desc, is_dev_status, hub_type_ok;
    assign is_hub_desc = setup_i.bm_type == RT_HUB_DESC && setup_i.b_request == REQ_GET_DESC;
    assign hub_type_ok = setup_i.w_value[15:8] == DT_HUB ||
        (setup_i.w_value[15:8] == DT_ZERO && accept_zero_desc_type);
    assign is_dev_status = setup_i.bm_type == RT_DEV_STD && setup_i.b_request == REQ_GET_STATUS &&
        setup_i.w_value == STATUS_WVALUE && setup_i.w_length == STATUS_LEN;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_o <= '0;
        end else begin
            resp_o <= '0;
            if (setup_i.valid && is_hub_desc) begin
                resp_o.valid <= 1'b1;
                resp_o.hub_desc <= cfg_ready_o && hub_type_ok;
                resp_o.stall <= !(cfg_ready_o && hub_type_ok);
            end else if (setup_i.valid && is_dev_status) begin
                resp_o.valid <= 1'b1;
                resp_o.dev_status <= 1'b1;
                resp_o.status_word <= {15'h0000, self_power_capable};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack one cycle after the strobe, dropped the cycle after
    logic [8:0] tab_idx_reg;
    logic wb_hit;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
        end
    end

    // writes land on the acknowledged edge, while the master still holds the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            led_div_reg <= LED_DIV_RST;
            tab_idx_reg <= 9'h000;
        end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i) begin
            if (wb_adr_i == REG_LED_DIV_OFS) begin
                if (wb_sel_i[0]) led_div_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) led_div_reg[15:8] <= wb_dat_i[15:8];
            end else if (wb_adr_i == REG_TAB_IDX_OFS) begin
                if (wb_sel_i[0]) tab_idx_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) tab_idx_reg[8] <= wb_dat_i[8];
            end
        end
    end

    // read data; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
                REG_STATE_OFS: wb_dat_o <= {24'h000000, 5'h00, state_reg};
                REG_OPTS_OFS: wb_dat_o <= {strmap_reg, langs_reg, opt_b_reg, opt_a_reg};
                REG_DESC_OFS: wb_dat_o <= {detach_reg, usable_reg, hub_char_o[7:0], nbr_ports_o};
                REG_LED_DIV_OFS: wb_dat_o <= {16'h0000, led_div_reg};
                REG_TAB_IDX_OFS: wb_dat_o <= {23'h0, tab_idx_reg};
                REG_TAB_DATA_OFS: wb_dat_o <= {24'h000000, tab_mem[tab_idx_reg]};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_zero_type_stall;
        @(posedge clk_i) disable iff (rst_i)
        setup_i.valid && is_hub_desc && setup_i.w_value[15:8] == DT_ZERO && !accept_zero_desc_type
        |=> resp_o.valid && resp_o.stall && !resp_o.hub_desc;
    endproperty
    a_zero_type_stall: assert property (p_zero_type_stall) else $error("zero type not stalled");

    property p_compound_char;
        @(posedge clk_i) disable iff (rst_i)
        $rose(cfg_ready_o) |-> hub_char_o[HC_COMPOUND_BIT] == $past(opt_a_reg[OPT_COMPOUND_BIT]);
    endproperty
    a_compound_char: assert property (p_compound_char) else $error("compound bit wrong");

    property p_fs_only;
        @(posedge clk_i) disable iff (rst_i)
        cfg_ready_o && opt_a_reg[OPT_FS_ONLY_BIT] |-> !hs_enable_o;
    endproperty
    a_fs_only: assert property (p_fs_only) else $error("high speed allowed");

    property p_leds_off;
        @(posedge clk_i) disable iff (rst_i)
        indicators_off |=> amber_o == {PORTS{~$past(amber_led_pol)}}
            && green_o == {PORTS{~$past(green_led_pol)}};
    endproperty
    a_leds_off: assert property (p_leds_off) else $error("indicator driven while off");

    property p_pwr_pol;
        @(posedge clk_i) disable iff (rst_i)
        cfg_ready_o ##1 cfg_ready_o |-> pwr_o == ($past(pwr_on_i) ^ {PORTS{~pwr_switch_pol}});
    endproperty
    a_pwr_pol: assert property (p_pwr_pol) else $error("power output polarity wrong");

    property p_oc_disabled;
        @(posedge clk_i) disable iff (rst_i)
        oc_detect_disable ##1 oc_detect_disable |-> oc_o == '0 && hub_char_o[HC_OC_NONE_BIT];
    endproperty
    a_oc_disabled: assert property (p_oc_disabled) else $error("over-current while disabled");

    property p_no_strings;
        @(posedge clk_i) disable iff (rst_i)
        cfg_ready_o && (langs_reg == 8'h00 || langs_reg > MAX_LANGS) |-> string_idx_o == 56'h0;
    endproperty
    a_no_strings: assert property (p_no_strings) else $error("string index with strings off");

    property p_status_reply;
        @(posedge clk_i) disable iff (rst_i)
        setup_i.valid && is_dev_status |=> resp_o.valid && resp_o.dev_status
            && resp_o.status_word[0] == self_power_capable;
    endproperty
    a_status_reply: assert property (p_status_reply) else $error("status request unanswered");

    property p_port_count;
        @(posedge clk_i) disable iff (rst_i)
        cfg_ready_o |-> nbr_ports_o <= 8'h04 && (usable_reg[3:0] != 4'h0 || nbr_ports_o == 8'h00);
    endproperty
    a_port_count: assert property (p_port_count) else $error("port count out of range");

endmodule
`default_nettype wire

// ### hcd_pkg.sv
// Purpose: shared constants and carrier types for the hub configuration image decoder
// Assumes: byte-wide reads of the configuration image arrive from a same-clock memory reader
// Notes: register offsets are byte addresses on a 32-bit classic Wishbone bus
`default_nettype none
package hcd_pkg;
    // image byte offsets
    localparam logic [15:0] IMG_OPT_A_OFS = 16'h0011;
    localparam logic [15:0] IMG_OPT_B_OFS = 16'h0012;
    localparam logic [15:0] IMG_LANGS_OFS = 16'h0014;
    localparam logic [15:0] IMG_STRMAP_OFS = 16'h0015;
    localparam logic [15:0] IMG_USABLE_OFS = 16'h0016;
    localparam logic [15:0] IMG_DETACH_OFS = 16'h0017;
    localparam logic [15:0] IMG_TABLE_OFS = 16'h0018;
    localparam int IMG_LAST_HDR_IDX = 6;
    // option byte A field positions
    localparam int OPT_ACCEPT_ZERO_BIT = 7;
    localparam int OPT_COMPOUND_BIT = 6;
    localparam int OPT_FS_ONLY_BIT = 5;
    localparam int OPT_IND_OFF_BIT = 4;
    localparam int OPT_GANGED_BIT = 2;
    localparam int OPT_ONE_TT_BIT = 1;
    // option byte B field positions
    localparam int OPT_AMBER_POL_BIT = 7;
    localparam int OPT_GREEN_POL_BIT = 6;
    localparam int OPT_SELF_PWR_BIT = 5;
    localparam int OPT_SQ_GATE_BIT = 4;
    localparam int OPT_PWR_POL_BIT = 3;
    localparam int OPT_OC_POL_BIT = 2;
    localparam int OPT_OC_OFF_BIT = 1;
    localparam int OPT_OC_PER_PORT_BIT = 0;
    // hub characteristics positions
    localparam int HC_COMPOUND_BIT = 2;
    localparam int HC_OC_PER_PORT_BIT = 3;
    localparam int HC_OC_NONE_BIT = 4;
    localparam int HC_IND_BIT = 7;
    // reset values of latched bytes, then the language limit and table sizes
    localparam logic [7:0] OPT_A_RST = 8'h00;
    localparam logic [7:0] OPT_B_RST = 8'h00;
    localparam logic [7:0] DETACH_RST = 8'hFF;
    localparam logic [7:0] MAX_LANGS = 8'h1F;
    localparam int TABLE_COUNT = 8;
    localparam int TABLE_BYTES = 496;
    // request codes
    localparam logic [7:0] RT_HUB_DESC = 8'hA0;
    localparam logic [7:0] RT_DEV_STD = 8'h80;
    localparam logic [7:0] REQ_GET_STATUS = 8'h00;
    localparam logic [7:0] REQ_GET_DESC = 8'h06;
    localparam logic [7:0] DT_HUB = 8'h29;
    localparam logic [7:0] DT_ZERO = 8'h00;
    localparam logic [15:0] STATUS_LEN = 16'h0002;
    localparam logic [15:0] STATUS_WVALUE = 16'h0000;
    // register byte addresses and the divider reset value
    localparam logic [7:0] REG_STATE_OFS = 8'h00;
    localparam logic [7:0] REG_OPTS_OFS = 8'h04;
    localparam logic [7:0] REG_DESC_OFS = 8'h08;
    localparam logic [7:0] REG_LED_DIV_OFS = 8'h0C;
    localparam logic [7:0] REG_TAB_IDX_OFS = 8'h10;
    localparam logic [7:0] REG_TAB_DATA_OFS = 8'h14;
    localparam logic [15:0] LED_DIV_RST = 16'h0FFF;

    typedef struct packed {
        logic valid;
        logic [7:0] bm_type;
        logic [7:0] b_request;
        logic [15:0] w_value;
        logic [15:0] w_length;
    } hcd_setup_type;

    typedef struct packed {
        logic valid;
        logic stall;
        logic hub_desc;
        logic dev_status;
        logic [15:0] status_word;
    } hcd_resp_type;
endpackage
`default_nettype wire

// ### hcd_image_model.sv
// Purpose: behavioural serial memory holding the hub configuration image
// Assumes: one byte is answered for each held read request
// Notes: answer delay is the variable lat; the data line wanders while idle
`timescale 1ns/10ps
`default_nettype none
module hcd_image_model (
    // clock
    input wire logic clk_i,
    // read port
    input wire logic rd_req_i,
    input wire logic [15:0] rd_addr_i,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o
);
    logic [7:0] mem [0:511];
    int lat = 3;
    int wait_cnt = 0;
    initial begin
        rd_valid_o = 1'b0;
        rd_data_o = 8'h00;
    end
    ////////////////////////////////////////////////////////////
    // one pulse per request; idle data inverts so stale bytes never look valid
    always @(posedge clk_i) begin
        rd_valid_o <= 1'b0;
        rd_data_o <= ~rd_data_o;
        if (rd_req_i && !rd_valid_o) begin
            if (wait_cnt >= lat) begin
                rd_valid_o <= 1'b1;
                rd_data_o <= mem[rd_addr_i[8:0]];
                wait_cnt <= 0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb_hcd_config_decoder.sv
// Purpose: self-checking bench for the hub configuration image decoder
// Assumes: image model answers reads slowly first, promptly later
// Notes: three images are loaded, each after its own reset
`timescale 1ns/10ps
`default_nettype none
module tb_hcd_config_decoder;
    import hcd_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rd_req_o, rd_valid_i, cfg_ready_o;
    logic hs_enable_o, multi_tt_o, self_power_o;
    logic [7:0] wb_adr_i, rd_data_i, nbr_ports_o, removable_o;
    logic [3:0] wb_sel_i, amber_on_i, green_on_i, pwr_on_i, oc_pin_i, amber_o, green_o, pwr_o, oc_o;
    logic [31:0] wb_dat_i, wb_dat_o, d;
    logic [15:0] rd_addr_o, hub_char_o;
    logic [55:0] string_idx_o;
    hcd_setup_type setup_i;
    hcd_resp_type r, resp_o;
    int fail_count = 0;
    int compares = 0;
    hcd_config_decoder u_hcd_config_decoder (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .rd_req_o, .rd_addr_o, .rd_valid_i, .rd_data_i, .setup_i, .resp_o,
        .cfg_ready_o, .hs_enable_o, .multi_tt_o, .self_power_o, .nbr_ports_o, .hub_char_o, .removable_o,
        .string_idx_o, .amber_on_i, .green_on_i, .pwr_on_i, .oc_pin_i, .amber_o, .green_o, .pwr_o, .oc_o);
    hcd_image_model u_hcd_image_model (.clk_i, .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o),
        .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i));
    // 40 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rst();
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    // bounded wait for the image to finish loading
    task automatic rdy();
        int n;
        for (n = 0; n < 400 && cfg_ready_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 400) begin
            fail_count++;
            print_verdict();
        end
        repeat (5) @(posedge clk_i); // pins settle within three cycles
    endtask
    // classic single cycle; request held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        d = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        if (n == 20) begin
            fail_count++;
            print_verdict();
        end
    endtask
    // one-cycle setup request; answer sampled in the cycle it stands
    task automatic req(input logic [7:0] bm, rq, input logic [15:0] wv);
        setup_i <= '{1'b1, bm, rq, wv, STATUS_LEN};
        @(posedge clk_i);
        setup_i <= '0;
        @(posedge clk_i);
        r = resp_o;
    endtask
    task automatic img(input logic [7:0] a, b, langs, smap);
        for (int i = 0; i < 512; i++) u_hcd_image_model.mem[i] = 8'(i * 5 + 1);
        {u_hcd_image_model.mem[17], u_hcd_image_model.mem[18]} = {a, b};
        {u_hcd_image_model.mem[20], u_hcd_image_model.mem[21]} = {langs, smap};
        {u_hcd_image_model.mem[22], u_hcd_image_model.mem[23]} = 16'h0906;
        {u_hcd_image_model.mem[40], u_hcd_image_model.mem[41]} = 16'h0403;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, rst_i} = 4'h1;
        {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'hF, 32'h0};
        setup_i = '0;
        {amber_on_i, green_on_i, pwr_on_i, oc_pin_i} = 16'h356E;
        img(8'hC4, 8'h28, 8'h01, 8'h05);
        rst();
        chk(cfg_ready_o, 1'b0);
        chk(removable_o, 8'h1E);
        chk(pwr_o, 4'hF);
        req(RT_HUB_DESC, REQ_GET_DESC, 16'h2900);
        chk({r.valid, r.stall}, 2'b11);
        rdy();
        chk({hs_enable_o, multi_tt_o, self_power_o, nbr_ports_o}, 11'h702);
        chk(removable_o, 8'h0C);
        chk(string_idx_o, 56'h00000000030001);
        chk({hub_char_o[7], hub_char_o[4:2], hub_char_o[1:0]}, 6'b100100);
        chk({amber_o, green_o, pwr_o, oc_o}, 16'hCA6F);
        wb(1'b1, REG_OPTS_OFS, 32'hFFFFFFFF);
        wb(1'b0, REG_OPTS_OFS, 32'h0);
        chk(d, 32'h050128C4);
        wb(1'b1, REG_TAB_IDX_OFS, 32'h3);
        wb(1'b0, REG_TAB_DATA_OFS, 32'h0);
        chk(d, {24'h0, u_hcd_image_model.mem[27]});
        wb(1'b0, 8'h40, 32'h0);
        chk(d, 32'h0);
        req(RT_HUB_DESC, REQ_GET_DESC, 16'h0000);
        chk({r.valid, r.stall, r.hub_desc}, 3'b101);
        req(RT_DEV_STD, REQ_GET_STATUS, STATUS_WVALUE);
        chk({r.valid, r.dev_status, r.status_word}, 18'h30001);
        // second image: strings off, indicators off, detection off, prompt memory
        img(8'h32, 8'h17, 8'h20, 8'hFF);
        u_hcd_image_model.lat = 0;
        rst();
        rdy();
        chk({hs_enable_o, multi_tt_o, self_power_o, string_idx_o}, 59'h0);
        chk({hub_char_o[7], hub_char_o[4:2], hub_char_o[1:0]}, 6'b011001);
        chk({amber_o, green_o, pwr_o, oc_o}, 16'hFF90);
        req(RT_HUB_DESC, REQ_GET_DESC, 16'h0000);
        chk({r.valid, r.stall}, 2'b11);
        req(RT_DEV_STD, REQ_GET_STATUS, STATUS_WVALUE);
        chk({r.valid, r.status_word}, 17'h10000);
        // third image: active-high indicators blinking with a short divider
        img(8'h00, 8'hD0, 8'h00, 8'h00);
        rst();
        rdy();
        wb(1'b0, REG_STATE_OFS, 32'h0);
        chk(d, 32'h4);
        req(RT_HUB_DESC, REQ_GET_DESC, 16'h2900);
        chk({r.valid, r.stall, r.hub_desc}, 3'b101);
        wb(1'b1, REG_LED_DIV_OFS, 32'h5);
        wb(1'b0, REG_LED_DIV_OFS, 32'h0);
        chk(d, 32'h5);
        for (int n = 0; n < 40 && amber_o !== 4'h3; n++) @(posedge clk_i);
        for (int n = 0; n < 40 && amber_o !== 4'h0; n++) @(posedge clk_i);
        repeat (5) @(posedge clk_i);
        chk({amber_o, green_o}, 8'h00);
        @(posedge clk_i);
        chk({amber_o, green_o}, 8'h35);
        print_verdict();
    end
endmodule
`default_nettype wire
